// ==== rtl/pwm_timer_pkg.sv ====
// How it works
// [R1] match zero ends each cycle: counter returns to zero on that match
// [R2] single-edge output falls on its own match register
// [R3] single-edge outputs rise at cycle start unless programmed constant low
// [R4] double-edge output rises on match n-1 and falls on match n
// [R5] rise before fall gives positive pulse, fall before rise negative pulse
// [R6] double-edge positions may sit anywhere within the cycle
// [R7] seven match registers serve six outputs; output 1 is single-edge, outputs 2 to 6 each single or double
// [R8] each match may continue, stop or reset the counter, optional flag
// [R9] counter clocks from the prescaled clock or from capture input edges
// [R10] match updates align with the cycle so no pulse is truncated
// [R11] software releases new match values before they take effect
// [R12] with pwm mode off the block is a plain 32-bit timer with prescaler
// [R13] period and width are whole counts, one shared repetition rate
// [R14] two independent blocks, each with its own counter
// [R15] released values move from shadow to active on the cycle match
// [R16] enabled matches set sticky flags that stay until software clears them
package pwm_timer_pkg;
   localparam int NUM_BLOCKS = 2;
   localparam int NUM_MATCH  = 7;
   localparam int NUM_OUT    = 6;
   localparam int CNT_W      = 32;
   localparam int IDX_W      = 3;
   localparam logic [CNT_W-1:0] COUNT_RESET = 32'h00000000;
   localparam logic [CNT_W-1:0] MATCH_RESET = 32'h00000000;
   localparam logic [CNT_W-1:0] COUNT_ONE   = 32'h00000001;

   typedef enum logic [1:0] {
      SRC_TIMER,
      SRC_RISE,
      SRC_FALL,
      SRC_BOTH
   } count_src_t;

   typedef struct packed {
      logic                 enable;
      logic                 counter_reset;
      logic                 pwm_mode;
      count_src_t           count_src;
      logic                 cap_sel;
      logic [CNT_W-1:0]     prescale;
      logic [NUM_MATCH-1:0] match_irq;
      logic [NUM_MATCH-1:0] match_rst;
      logic [NUM_MATCH-1:0] match_stop;
      logic [NUM_OUT:1]     out_en;
      logic [NUM_OUT:2]     dbl_edge;
   } blk_cfg_t;

   typedef struct packed {
      logic                 wr;
      logic [IDX_W-1:0]     idx;
      logic [CNT_W-1:0]     data;
      logic [NUM_MATCH-1:0] latch;
      logic [NUM_MATCH-1:0] flag_clr;
   } match_wr_t;
endpackage

// ==== rtl/match_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module match_unit #(
   parameter int CW = 32
) (
   input  wire logic          ref_clk_in,
   input  wire logic          nrst_in,
   input  wire logic          pwm_mode_in,
   input  wire logic          wr_in,
   input  wire logic [CW-1:0] data_in,
   input  wire logic          latch_in,
   input  wire logic          boundary_in,
   input  wire logic          tick_in,
   input  wire logic [CW-1:0] count_in,
   output logic      [CW-1:0] active_out,
   output logic               hit_out
);
   logic [CW-1:0] shadow_r;
   logic [CW-1:0] shadow_nxt;
   logic [CW-1:0] active_r;
   logic [CW-1:0] active_nxt;
   logic          pend_r;
   logic          pend_nxt;

   always_comb
   begin
      shadow_nxt = shadow_r;
      active_nxt = active_r;
      pend_nxt   = pend_r;
      if (wr_in)
      begin
         shadow_nxt = data_in;
      end
      if (!pwm_mode_in)
      begin
         // plain timer: writes act at once
         if (wr_in)
         begin
            active_nxt = data_in;  // [R12]
         end
         pend_nxt = 1'b0;
      end
      else
      begin
         if (boundary_in && pend_r)
         begin
            active_nxt = shadow_r;  // [R15] [R10]
            pend_nxt   = 1'b0;
         end
         // a release in the transfer cycle is kept for the next boundary
         if (latch_in)
         begin
            pend_nxt = 1'b1;  // [R11]
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         shadow_r <= pwm_timer_pkg::MATCH_RESET;
         active_r <= pwm_timer_pkg::MATCH_RESET;
         pend_r   <= 1'b0;
      end
      else
      begin
         shadow_r <= shadow_nxt;
         active_r <= active_nxt;
         pend_r   <= pend_nxt;
      end
   end

   // value in force after this edge, so a release taken at a boundary decides that rise
   assign active_out = active_nxt;
   assign hit_out    = tick_in && (count_in == active_r);
endmodule
`default_nettype wire

// ==== rtl/multi_channel_pwm_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module multi_channel_pwm_timer #(
   parameter int NUM_BLOCKS = pwm_timer_pkg::NUM_BLOCKS
) (
   input  wire logic                                             ref_clk_in,
   input  wire logic                                             nrst_in,
   input  wire pwm_timer_pkg::blk_cfg_t  [NUM_BLOCKS-1:0]        cfg_in,
   input  wire pwm_timer_pkg::match_wr_t [NUM_BLOCKS-1:0]        match_wr_in,
   input  wire logic                     [NUM_BLOCKS-1:0][1:0]   cap_in,
   output logic                          [NUM_BLOCKS-1:0][5:0]   pwm_out,
   output logic                          [NUM_BLOCKS-1:0][6:0]   flag_out,
   output logic                          [NUM_BLOCKS-1:0][31:0]  count_out,
   output logic                          [NUM_BLOCKS-1:0]        stopped_out
);
   localparam int NM = pwm_timer_pkg::NUM_MATCH;
   localparam int NO = pwm_timer_pkg::NUM_OUT;
   localparam int CW = pwm_timer_pkg::CNT_W;

   genvar b;
   genvar m;
   generate
      for (b = 0; b < NUM_BLOCKS; b = b + 1)
      begin : g_blk  // [R14]
         pwm_timer_pkg::blk_cfg_t  cfg;
         pwm_timer_pkg::match_wr_t mw;
         logic [CW-1:0] tc_r;
         logic [CW-1:0] tc_nxt;
         logic [CW-1:0] pc_r;
         logic [CW-1:0] pc_nxt;
         logic [1:0]    cap_prev_r;
         logic [1:0]    cap_prev_nxt;
         logic          cap_last;
         logic          stop_r;
         logic          stop_nxt;
         logic [NO:1]   out_r;
         logic [NO:1]   out_nxt;
         logic [NM-1:0] flag_r;
         logic [NM-1:0] flag_nxt;
         logic          cap_now;
         logic          step;
         logic          run;
         logic          tick;
         logic          cycle_end;
         logic          boundary;
         logic          rst_hit;
         logic [NM-1:0] hit;
         logic [NO:1]   dbl;
         logic [CW-1:0] act [NM];

         assign cfg = cfg_in[b];
         assign mw  = match_wr_in[b];

         for (m = 0; m < NM; m = m + 1)
         begin : g_match  // [R7]
            match_unit #(
               .CW (CW)
            ) u_match (
               .ref_clk_in  (ref_clk_in),
               .nrst_in     (nrst_in),
               .pwm_mode_in (cfg.pwm_mode),
               .wr_in       (mw.wr && (int'(mw.idx) == m)),
               .data_in     (mw.data),
               .latch_in    (mw.latch[m]),
               .boundary_in (boundary),
               .tick_in     (tick),
               .count_in    (tc_r),
               .active_out  (act[m]),
               .hit_out     (hit[m])
            );
         end

         assign cap_now = cfg.cap_sel ? cap_in[b][1] : cap_in[b][0];
         // both pins are tracked so a select change never fakes an edge
         assign cap_last = cfg.cap_sel ? cap_prev_r[1] : cap_prev_r[0];
         // output 1 has no partner below it, so it is always single-edge
         assign dbl = {cfg.dbl_edge, 1'b0};

         // counting source selects the prescaler's input
         always_comb
         begin
            case (cfg.count_src)  // [R9]
               pwm_timer_pkg::SRC_TIMER: step = 1'b1;
               pwm_timer_pkg::SRC_RISE:  step = cap_now && !cap_last;
               pwm_timer_pkg::SRC_FALL:  step = !cap_now && cap_last;
               default:                  step = cap_now != cap_last;
            endcase
         end

         assign run       = cfg.enable && !stop_r && !cfg.counter_reset;
         assign tick      = run && step && (pc_r == cfg.prescale);  // [R12]
         // in pwm mode match zero always closes the cycle
         assign cycle_end = hit[0] && cfg.pwm_mode;  // [R1]
         assign boundary  = cycle_end;
         assign rst_hit   = |(hit & cfg.match_rst) || cycle_end;  // [R8]

         always_comb
         begin
            tc_nxt       = tc_r;
            pc_nxt       = pc_r;
            cap_prev_nxt = cap_in[b];
            stop_nxt     = stop_r;
            if (cfg.counter_reset)
            begin
               tc_nxt = pwm_timer_pkg::COUNT_RESET;
               pc_nxt = pwm_timer_pkg::COUNT_RESET;
            end
            else if (run && step)
            begin
               if (tick)
               begin
                  pc_nxt = pwm_timer_pkg::COUNT_RESET;
                  if (rst_hit)
                  begin
                     tc_nxt = pwm_timer_pkg::COUNT_RESET;  // [R1] [R13]
                  end
                  else
                  begin
                     tc_nxt = tc_r + pwm_timer_pkg::COUNT_ONE;
                  end
               end
               else
               begin
                  pc_nxt = pc_r + pwm_timer_pkg::COUNT_ONE;
               end
            end
            // stop holds until software drops enable
            if (!cfg.enable)
            begin
               stop_nxt = 1'b0;
            end
            else if (|(hit & cfg.match_stop))
            begin
               stop_nxt = 1'b1;  // [R8]
            end
         end

         always_comb
         begin
            out_nxt = out_r;
            for (int n = 1; n <= NO; n = n + 1)
            begin
               if (!cfg.pwm_mode || !cfg.out_en[n])
               begin
                  out_nxt[n] = 1'b0;
               end
               else if (dbl[n])
               begin
                  // either edge anywhere; fall wins on a tie
                  if (hit[n])
                  begin
                     out_nxt[n] = 1'b0;  // [R4] [R5] [R6]
                  end
                  else if (hit[n-1])
                  begin
                     out_nxt[n] = 1'b1;  // [R4] [R5] [R6]
                  end
               end
               else
               begin
                  if (cycle_end)
                  begin
                     // zero match means constant low
                     out_nxt[n] = act[n] != pwm_timer_pkg::MATCH_RESET;  // [R3]
                  end
                  else if (hit[n])
                  begin
                     out_nxt[n] = 1'b0;  // [R2]
                  end
               end
            end
         end

         // a new match beats a clear in the same cycle
         always_comb
         begin
            flag_nxt = flag_r & ~mw.flag_clr;
            flag_nxt = flag_nxt | (hit & cfg.match_irq);  // [R16] [R8]
         end

         always_ff @(posedge ref_clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
            begin
               tc_r       <= pwm_timer_pkg::COUNT_RESET;
               pc_r       <= pwm_timer_pkg::COUNT_RESET;
               cap_prev_r <= 2'h0;
               stop_r     <= 1'b0;
            end
            else
            begin
               tc_r       <= tc_nxt;
               pc_r       <= pc_nxt;
               cap_prev_r <= cap_prev_nxt;
               stop_r     <= stop_nxt;
            end
         end

         always_ff @(posedge ref_clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
            begin
               out_r <= '0;
            end
            else
            begin
               out_r <= out_nxt;
            end
         end

         always_ff @(posedge ref_clk_in or negedge nrst_in)
         begin
            if (!nrst_in)
            begin
               flag_r <= '0;
            end
            else
            begin
               flag_r <= flag_nxt;
            end
         end

         assign pwm_out[b]     = out_r;
         assign flag_out[b]    = flag_r;
         assign count_out[b]   = tc_r;
         assign stopped_out[b] = stop_r;
      end
   endgenerate
endmodule
`default_nettype wire

// ==== bench/multi_channel_pwm_timer_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_checker #(
   parameter int NUM_BLOCKS = 2
) (
   input wire logic                                      ref_clk_in,
   input wire logic                                      nrst_in,
   input wire pwm_timer_pkg::blk_cfg_t  [NUM_BLOCKS-1:0] cfg_in,
   input wire pwm_timer_pkg::match_wr_t [NUM_BLOCKS-1:0] match_wr_in,
   input wire logic [NUM_BLOCKS-1:0][1:0]                cap_in,
   input wire logic [NUM_BLOCKS-1:0][5:0]                pwm_out,
   input wire logic [NUM_BLOCKS-1:0][6:0]                flag_out,
   input wire logic [NUM_BLOCKS-1:0][31:0]               count_out,
   input wire logic [NUM_BLOCKS-1:0]                     stopped_out
);
   wire pwm_timer_pkg::blk_cfg_t c0 = cfg_in[0];
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   count_hold_a: assert property (c0.counter_reset |=> count_out[0] == 32'h00000000)
      else $error("count not held");
   pwm_off_a: assert property (!c0.pwm_mode |=> pwm_out[0] == 6'h00)
      else $error("output active outside pwm mode");
   rise_wrap_a: assert property ($rose(pwm_out[0][0]) |-> count_out[0] == 32'h00000000)
      else $error("rise away from cycle start");
   count_step_a: assert property ((c0.enable && !c0.counter_reset && !stopped_out[0]) |=>
      (count_out[0] == $past(count_out[0]) + 32'h00000001 || count_out[0] == 32'h00000000 || $stable(count_out[0])))
      else $error("counter jumped");
   flag_keep_a: assert property ((flag_out[0][1] && !match_wr_in[0].flag_clr[1]) |=> flag_out[0][1])
      else $error("flag lost");
   flag_cause_a: assert property ($rose(flag_out[0][1]) |-> $past(c0.match_irq[1]))
      else $error("flag without enable");
   stop_cause_a: assert property ($rose(stopped_out[0]) |-> $past(c0.match_stop) != 7'h00)
      else $error("stop without enable");
   stop_freeze_a: assert property ((stopped_out[0] && !c0.counter_reset) |=> $stable(count_out[0]))
      else $error("stopped counter moved");
endmodule
bind multi_channel_pwm_timer pwm_timer_checker #(.NUM_BLOCKS(NUM_BLOCKS)) u_chk (
   .ref_clk_in  (ref_clk_in),
   .nrst_in     (nrst_in),
   .cfg_in      (cfg_in),
   .match_wr_in (match_wr_in),
   .cap_in      (cap_in),
   .pwm_out     (pwm_out),
   .flag_out    (flag_out),
   .count_out   (count_out),
   .stopped_out (stopped_out)
);
`default_nettype wire

// ==== bench/pwm_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
   input  wire logic        ref_clk_in,
   input  wire logic [5:0]  pwm_in,
   output logic [5:0][15:0] width_out,
   output logic [5:0][15:0] period_out
);
   // a load sees only the pins: high time and period counted from each rise
   logic [5:0][15:0] hi_r;
   logic [5:0][15:0] per_r;
   logic [5:0]       last_r = 6'h00;
   always @(posedge ref_clk_in)
   begin
      for (int k = 0; k < 6; k++)
      begin
         if (pwm_in[k] && !last_r[k])
         begin
            width_out[k] <= hi_r[k];
            period_out[k] <= per_r[k];
            hi_r[k] <= 16'h0001;
            per_r[k] <= 16'h0001;
         end
         else
         begin
            hi_r[k] <= hi_r[k] + 16'(pwm_in[k]);
            per_r[k] <= per_r[k] + 16'h0001;
         end
      end
      last_r <= pwm_in;
   end
endmodule
`default_nettype wire

// ==== bench/multi_channel_pwm_timer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module multi_channel_pwm_timer_test;
   logic                            ref_clk = 1'b0;
   logic                            nrst = 1'b0;
   pwm_timer_pkg::blk_cfg_t  [1:0]  cfg;
   pwm_timer_pkg::match_wr_t [1:0]  mwr;
   logic [1:0][1:0]                 cap;
   logic [1:0][5:0]                 pwm;
   logic [1:0][6:0]                 flag;
   logic [1:0][31:0]                cnt;
   logic [1:0]                      stp;
   logic [5:0][15:0]                w0, p0, w1, p1;
   logic [31:0]                     t0;
   logic                            lo;
   int                              fails = 0;
   int                              num_checks = 0;
   // widths listed from bit 5 down to bit 0; bit 2 is the constant-low output
   logic [5:0][15:0] ew = {16'h6, 16'h3, 16'h6, 16'h0, 16'h4, 16'h4};
   logic [6:0][31:0] mv = {32'h8, 32'h2, 32'h5, 32'h0, 32'h7, 32'h3, 32'h9};
   always #25 ref_clk = ~ref_clk;
   multi_channel_pwm_timer u_dut (.ref_clk_in(ref_clk), .nrst_in(nrst), .cfg_in(cfg), .match_wr_in(mwr),
      .cap_in(cap), .pwm_out(pwm), .flag_out(flag), .count_out(cnt), .stopped_out(stp));
   pwm_load_model u_load0 (.ref_clk_in(ref_clk), .pwm_in(pwm[0]), .width_out(w0), .period_out(p0));
   pwm_load_model u_load1 (.ref_clk_in(ref_clk), .pwm_in(pwm[1]), .width_out(w1), .period_out(p1));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // strobes drop for a cycle so back-to-back calls never retime one edge
   task automatic wr(input int b, input logic [2:0] i, input logic [31:0] d);
      mwr[b].wr = 1'b1;
      mwr[b].idx = i;
      mwr[b].data = d;
      cyc(1);
      mwr[b].wr = 1'b0;
      cyc(1);
   endtask
   task automatic pulse(input logic [6:0] l, input logic [6:0] c);
      mwr[0].latch = l;
      mwr[0].flag_clr = c;
      cyc(1);
      mwr[0].latch = 7'h00;
      mwr[0].flag_clr = 7'h00;
      cyc(1);
   endtask
   task automatic restart(input int b);
      cfg[b].counter_reset = 1'b1;
      cyc(1);
      cfg[b].enable = 1'b1;
      cfg[b].counter_reset = 1'b0;
   endtask
   initial
   begin
      cfg = '0;
      mwr = '0;
      cap = '0;
      cfg[0].counter_reset = 1'b1;
      cfg[1].counter_reset = 1'b1;
      cyc(8);
      nrst = 1'b1;
      wr(0, 3'h1, 32'h00000004);
      cfg[0].match_rst = 7'h02;
      cfg[0].match_irq = 7'h02;
      restart(0);
      t0 = '0;
      repeat (20)
      begin
         cyc(1);
         if (cnt[0] > t0)
            t0 = cnt[0];
      end
      chk(t0, 32'h00000004);
      cfg[0].match_irq = 7'h00;
      cyc(3);
      chk(32'(flag[0]), 32'h00000002);
      pulse(7'h00, 7'h02);
      chk(32'(flag[0]), 32'h00000000);
      cfg[0].match_rst = 7'h00;
      cfg[0].match_stop = 7'h02;
      restart(0);
      for (int k = 0; k < 200 && stp[0] !== 1'b1; k++)
         cyc(1);
      chk(32'(stp[0]), 32'h00000001);
      t0 = cnt[0];
      cyc(5);
      chk(cnt[0], t0);
      cfg[0].enable = 1'b0;
      cfg[0].match_stop = 7'h00;
      cyc(2);
      chk(32'(stp[0]), 32'h00000000);
      cfg[0].prescale = 32'h00000002;
      restart(0);
      cyc(4);
      t0 = cnt[0];
      cyc(30);
      chk(cnt[0] - t0, 32'h0000000A);
      cfg[0].prescale = 32'h00000000;
      for (int s = 1; s < 4; s++)
      begin
         // both pin selects get used; a wrong select sees an idle pin and counts nothing
         cfg[0].cap_sel = s[0];
         cfg[0].count_src = pwm_timer_pkg::count_src_t'(s);
         restart(0);
         repeat (5)
         begin
            cap[0][cfg[0].cap_sel] = 1'b1;
            cyc(2);
            cap[0][cfg[0].cap_sel] = 1'b0;
            cyc(2);
         end
         chk(cnt[0], (s == 3) ? 32'h0000000A : 32'h00000005);
      end
      // matches loaded outside pwm mode take effect at once, so no release is needed here
      cfg[0].counter_reset = 1'b1;
      cfg[0].count_src = pwm_timer_pkg::SRC_TIMER;
      for (int i = 0; i < 7; i++)
         wr(0, 3'(i), mv[i]);
      wr(1, 3'h0, 32'h00000005);
      wr(1, 3'h1, 32'h00000002);
      cfg[0].pwm_mode = 1'b1;
      cfg[0].out_en = 6'h3F;
      cfg[0].dbl_edge = 5'h11;
      cfg[0].match_irq = 7'h01;
      cfg[1].pwm_mode = 1'b1;
      cfg[1].out_en = 6'h01;
      cfg[1].prescale = 32'h00000001;
      restart(0);
      restart(1);
      lo = 1'b0;
      repeat (60)
      begin
         cyc(1);
         lo = lo | pwm[0][2];
      end
      chk(32'(lo), 32'h00000000);
      chk(32'(flag[0]), 32'h00000001);
      for (int k = 0; k < 6; k++)
      begin
         if (k != 2)
         begin
            chk(32'(w0[k]), 32'(ew[k]));
            chk(32'(p0[k]), 32'h0000000A);
         end
      end
      chk(32'(p1[0]), 32'h0000000C);
      chk(32'(w1[0]), 32'h00000006);
      wr(0, 3'h1, 32'h00000007);
      wr(0, 3'h2, 32'h00000003);
      cyc(40);
      chk(32'(w0[0]), 32'h00000004);
      pulse(7'h06, 7'h00);
      repeat (40)
      begin
         cyc(1);
         if (w0[0] !== 16'h0004 && w0[0] !== 16'h0008)
            chk(32'(w0[0]), 32'h00000008);
      end
      chk(32'(w0[0]), 32'h00000008);
      chk(32'(w0[1]), 32'h00000006);
      // mid-run reset: registers clear, matches return to zero
      nrst = 1'b0;
      cyc(2);
      chk(32'({pwm[0], flag[0], stp[0]}), 32'h00000000);
      chk(cnt[0], 32'h00000000);
      nrst = 1'b1;
      cyc(4);
      chk(32'(pwm[0]), 32'h00000000);
      chk(cnt[0], 32'h00000000);
      test_done();
   end
endmodule
`default_nettype wire
